// >>> core/wdt_cfg.svh
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// bus addresses, low 16 bits
`define WDT_ADDR_WR_CNT_CSR 16'hFFBC
`define WDT_ADDR_WR_RST_CSR 16'hFFBE
`define WDT_ADDR_RD_CSR     16'hFFBC
`define WDT_ADDR_RD_CNT     16'hFFBD
`define WDT_ADDR_RD_RST_CSR 16'hFFBF

// password keys in the upper byte of a word write
`define WDT_KEY_CNT         8'h5A
`define WDT_KEY_CSR         8'hA5
`define WDT_KEY_RST_BITS    8'h5A
`define WDT_KEY_RST_CLR     8'hA5
`define WDT_RST_CLR_DATA    8'h00

// timer_control_status fields
`define WDT_CSR_OVF_BIT     7
`define WDT_CSR_MODE_BIT    6
`define WDT_CSR_TME_BIT     5
`define WDT_CSR_RSV_ONES    2'h3
`define WDT_CSR_RESET       8'h18

// reset_control_status fields
`define WDT_RST_WATCHDOG_OVERFLOW_FLAG_BIT    7
`define WDT_RST_CHIP_RESET_ENABLE_BIT    6
`define WDT_RST_RESET_TYPE_SELECT_BIT    5
`define WDT_RST_RSV_ONES    5'h1F
`define WDT_RST_RESET       8'h1F

`define WDT_CNT_RESET       8'h00
`define WDT_CNT_MAX         8'hFF

// timing in states; one state is one clk_sys cycle
`define WDT_OVF_STATES_CHIP_RESET_ENABLE 10'd132
`define WDT_OVF_STATES_NORST 10'd130
`define WDT_CHIP_RST_STATES 10'd518

`endif

// >>> core/wdt_pkg.sv
package wdt_pkg;

  typedef enum logic [2:0] {
    WDT_DIV2      = 3'h0,
    WDT_DIV64     = 3'h1,
    WDT_DIV128    = 3'h2,
    WDT_DIV512    = 3'h3,
    WDT_DIV2048   = 3'h4,
    WDT_DIV8192   = 3'h5,
    WDT_DIV32768  = 3'h6,
    WDT_DIV131072 = 3'h7
  } wdt_clksel_e;

  typedef enum logic {
    WDT_MODE_INTERVAL = 1'b0,
    WDT_MODE_WATCHDOG = 1'b1
  } wdt_mode_e;

  typedef enum logic {
    WDT_RST_POWER_ON = 1'b0,
    WDT_RST_MANUAL   = 1'b1
  } wdt_rst_type_e;

endpackage

// >>> core/wdt_prescaler.sv
`timescale 1ns/100ps
module wdt_prescaler #(
  parameter int PW = 17
) (
  input  wire logic              clk_sys,  // system clock
  input  wire logic              rstn,     // async reset, active low
  input  wire wdt_pkg::wdt_clksel_e sel,   // divider choice
  output logic                   tick      // one pulse per divided period
);

  logic [PW-1:0] div_reg;
  logic [PW-1:0] div_next;
  logic [PW-1:0] sel_mask;

  // mask of low bits that must all be one at the end of a period
  function automatic logic [PW-1:0] div_mask(input wdt_pkg::wdt_clksel_e s);
    logic [PW-1:0] m;
    m = '0;
    unique case (s)
      wdt_pkg::WDT_DIV2:      m = PW'(17'h00001);
      wdt_pkg::WDT_DIV64:     m = PW'(17'h0003F);
      wdt_pkg::WDT_DIV128:    m = PW'(17'h0007F);
      wdt_pkg::WDT_DIV512:    m = PW'(17'h001FF);
      wdt_pkg::WDT_DIV2048:   m = PW'(17'h007FF);
      wdt_pkg::WDT_DIV8192:   m = PW'(17'h01FFF);
      wdt_pkg::WDT_DIV32768:  m = PW'(17'h07FFF);
      wdt_pkg::WDT_DIV131072: m = PW'(17'h1FFFF);
    endcase
    return m;
  endfunction

  // one free-running chain serves all eight choices
  assign div_next = div_reg + PW'(1); // R21
  assign sel_mask = div_mask(sel);
  assign tick     = ((div_reg & sel_mask) == sel_mask); // R10

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

endmodule

// >>> core/wdt_top.sv
// Operation
// R1: 8-bit counter counts divided clock while enabled
// R2: rollover raises overflow output or interval request
// R3: counter zeroed by reset, standby, disable; software standby only freezes it here
// R4: control/status resets to 18, survives soft standby
// R5: interval flag set only on interval overflow
// R6: interval flag clears after read then zero
// R7: bit 6 selects interval or watchdog mode
// R8: bit 5 enables counter, else held zero
// R9: reserved bits always read as one
// R10: clock select picks one of eight dividers
// R11: reset status register reset only by pin
// R12: watchdog flag set only on watchdog overflow
// R13: watchdog flag clears after read then zero
// R14: flags take only zero writes
// R15: bit 6 enables chip reset on overflow
// R16: bit 5 picks power-on or manual reset
// R17: keyed word writes select counter or control
// R18: keyed word writes clear flag or set bits
// R19: overflow output low 132 or 130 states
// R20: chip reset held for 518 states
// R21: one free-running prescaler feeds all choices
// R22: interval request follows interval flag
`timescale 1ns/100ps
`include "wdt_cfg.svh"
module wdt_top (
  input  wire logic        clk_sys,          // 40 MHz system clock
  input  wire logic        rstn,             // reset pin, async, active low
  input  wire logic        hw_standby,       // hardware standby level
  input  wire logic        sw_standby,       // software standby level
  input  wire logic [15:0] bus_addr,         // cpu address, low 16 bits
  input  wire logic        bus_wr,           // write strobe, one cycle
  input  wire logic        bus_word,         // 1 = word access
  input  wire logic [15:0] bus_wdata,        // write data
  input  wire logic        bus_rd,           // read strobe, one cycle
  output logic       [7:0] bus_rdata,        // read data, registered
  output logic             overflow_out_n,   // watchdog overflow pin
  output logic             interval_irq,     // interval interrupt request
  output logic             chip_reset_req,   // internal chip reset request
  output logic             chip_reset_manual // 1 = manual, 0 = power-on
);

  // control and status state
  logic [7:0] overflow_counter_reg;
  logic [7:0] overflow_counter_next;
  logic       interval_overflow_flag_reg;
  logic       interval_overflow_flag_next;
  wdt_pkg::wdt_mode_e   mode_select_reg;
  logic       timer_enable_bit_reg;
  wdt_pkg::wdt_clksel_e clk_sel_reg;
  logic       watchdog_overflow_flag_reg;
  logic       watchdog_overflow_flag_next;
  logic       chip_reset_enable_reg;
  wdt_pkg::wdt_rst_type_e reset_type_select_reg;
  logic       ovf_armed_reg;
  logic       ovf_armed_next;
  logic       watchdog_overflow_flag_armed_reg;
  logic       watchdog_overflow_flag_armed_next;
  logic [9:0] out_cnt_reg;
  logic [9:0] out_cnt_next;
  logic [9:0] rst_cnt_reg;
  logic [9:0] rst_cnt_next;
  logic       out_n_reg;
  logic       rst_req_reg;
  logic       rst_manual_reg;
  logic [7:0] rdata_reg;

  // reset images as vectors, so single fields can be picked from them
  localparam logic [7:0] CSR_INIT = `WDT_CSR_RESET;
  localparam logic [7:0] RST_INIT = `WDT_RST_RESET;
  // wide enough for the slowest divider
  localparam int         PRESC_W  = 17;

  // decode
  wire logic       tick;
  wire logic [7:0] wr_key;
  wire logic [7:0] wr_low;
  wire logic       out_busy;
  wire logic       wr_ok;
  wire logic       wr_cnt;
  wire logic       wr_csr;
  wire logic       wr_rst_bits;
  wire logic       wr_rst_clr;
  wire logic       rd_csr;
  wire logic       rd_cnt;
  wire logic       rd_rst;
  wire logic       counting;
  wire logic       rollover;
  wire logic       ovf_interval;
  wire logic       ovf_watchdog;
  wire logic       csr_init;
  wire logic [7:0] csr_view;
  wire logic [7:0] rst_view;
  wire logic [7:0] rd_mux;
  wire logic       ovf_clear;
  wire logic       watchdog_overflow_flag_clear;

  // keyed word write to one address; shared by all four write decodes
  function automatic logic keyed_write(input logic [15:0] addr,
                                       input logic [7:0]  key,
                                       input logic [15:0] want_addr,
                                       input logic [7:0]  want_key);
    return (addr == want_addr) && (key == want_key);
  endfunction

  // one step of a pulse timer: load on start, else count down to zero
  function automatic logic [9:0] pulse_step(input logic       start,
                                            input logic [9:0] load,
                                            input logic [9:0] cur);
    return start ? load : ((cur != 10'd0) ? cur - 10'd1 : cur);
  endfunction

  wdt_prescaler #(
    .PW(PRESC_W)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .rstn   (rstn),
    .sel    (clk_sel_reg),
    .tick   (tick)
  );

  assign wr_key   = bus_wdata[15:8];
  assign wr_low   = bus_wdata[7:0];
  // registers are locked while the overflow pulse is out
  assign out_busy = (out_cnt_reg != 10'd0);
  // byte writes never reach the registers
  assign wr_ok    = bus_wr && bus_word && !out_busy; // R17

  assign wr_cnt      = wr_ok && keyed_write(bus_addr, wr_key,
                                            `WDT_ADDR_WR_CNT_CSR, `WDT_KEY_CNT); // R17
  assign wr_csr      = wr_ok && keyed_write(bus_addr, wr_key,
                                            `WDT_ADDR_WR_CNT_CSR, `WDT_KEY_CSR); // R17
  assign wr_rst_bits = wr_ok && keyed_write(bus_addr, wr_key,
                                            `WDT_ADDR_WR_RST_CSR, `WDT_KEY_RST_BITS); // R18
  assign wr_rst_clr  = wr_ok && keyed_write(bus_addr, wr_key,
                                            `WDT_ADDR_WR_RST_CSR, `WDT_KEY_RST_CLR)
                       && (wr_low == `WDT_RST_CLR_DATA); // R18

  // reads need no key
  assign rd_csr = bus_rd && (bus_addr == `WDT_ADDR_RD_CSR);
  assign rd_cnt = bus_rd && (bus_addr == `WDT_ADDR_RD_CNT);
  assign rd_rst = bus_rd && (bus_addr == `WDT_ADDR_RD_RST_CSR);

  // software standby freezes the count without clearing it
  assign counting = timer_enable_bit_reg && tick && !sw_standby; // R1 R3
  assign rollover = counting && (overflow_counter_reg == `WDT_CNT_MAX); // R2
  assign ovf_interval = rollover
                        && (mode_select_reg == wdt_pkg::WDT_MODE_INTERVAL); // R2 R7
  assign ovf_watchdog = rollover
                        && (mode_select_reg == wdt_pkg::WDT_MODE_WATCHDOG); // R2 R7
  // watchdog overflow reinitialises counter and control even without chip reset
  assign csr_init = hw_standby || ovf_watchdog; // R4 R15

  // reserved positions are fixed ones
  assign csr_view = {interval_overflow_flag_reg, mode_select_reg,
                     timer_enable_bit_reg, `WDT_CSR_RSV_ONES, clk_sel_reg}; // R9
  assign rst_view = {watchdog_overflow_flag_reg, chip_reset_enable_reg,
                     reset_type_select_reg, `WDT_RST_RSV_ONES}; // R9
  // unmapped addresses read zero
  assign rd_mux = rd_csr ? csr_view :
                  rd_cnt ? overflow_counter_reg :
                  rd_rst ? rst_view : 8'h00;

  // counter: write beats increment; disable and hardware standby beat both
  assign overflow_counter_next =
      (hw_standby || !timer_enable_bit_reg || ovf_watchdog) ? `WDT_CNT_RESET : // R3 R8
      wr_cnt   ? wr_low :                                 // R17
      counting ? overflow_counter_reg + 8'h01 :           // R1
      overflow_counter_reg;

  // flag clear needs an earlier read that saw the flag set
  assign ovf_clear = wr_csr && !wr_low[`WDT_CSR_OVF_BIT] && ovf_armed_reg; // R6 R14
  assign watchdog_overflow_flag_clear = wr_rst_clr && watchdog_overflow_flag_armed_reg; // R13 R14

  // set wins over a clear in the same cycle
  assign interval_overflow_flag_next =
      hw_standby   ? 1'b0 :
      ovf_interval ? 1'b1 :                               // R5
      ovf_clear    ? 1'b0 :                               // R6
      interval_overflow_flag_reg;

  assign watchdog_overflow_flag_next =
      ovf_watchdog ? 1'b1 :                               // R12
      watchdog_overflow_flag_clear   ? 1'b0 :                               // R13
      watchdog_overflow_flag_reg;

  // a read during the overflow pulse is not recognised for arming
  assign ovf_armed_next =
      ovf_clear ? 1'b0 :
      hw_standby ? 1'b0 :                 // standby clears the flag, so the arm goes too
      (rd_csr && !out_busy && interval_overflow_flag_reg) ? 1'b1 : // R6
      (!interval_overflow_flag_reg) ? 1'b0 :
      ovf_armed_reg;

  // either status read arms the watchdog flag clear
  assign watchdog_overflow_flag_armed_next =
      watchdog_overflow_flag_clear ? 1'b0 :
      ((rd_csr || rd_rst) && !out_busy && watchdog_overflow_flag_reg) ? 1'b1 : // R13
      (!watchdog_overflow_flag_reg) ? 1'b0 :
      watchdog_overflow_flag_armed_reg;

  // registers stay locked for the whole low time
  assign out_cnt_next = pulse_step(ovf_watchdog,
                                   chip_reset_enable_reg ? `WDT_OVF_STATES_CHIP_RESET_ENABLE
                                                         : `WDT_OVF_STATES_NORST,
                                   out_cnt_reg); // R19

  assign rst_cnt_next = pulse_step(ovf_watchdog && chip_reset_enable_reg,
                                   `WDT_CHIP_RST_STATES, rst_cnt_reg); // R15 R20

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      overflow_counter_reg <= `WDT_CNT_RESET; // R3
    end else begin
      overflow_counter_reg <= overflow_counter_next;
    end
  end

  // timer_control_status; software standby leaves it alone
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      interval_overflow_flag_reg <= CSR_INIT[`WDT_CSR_OVF_BIT]; // R4
      mode_select_reg            <= wdt_pkg::WDT_MODE_INTERVAL;
      timer_enable_bit_reg       <= CSR_INIT[`WDT_CSR_TME_BIT];
      clk_sel_reg                <= wdt_pkg::WDT_DIV2;
    end else begin
      interval_overflow_flag_reg <= interval_overflow_flag_next;
      if (csr_init) begin
        mode_select_reg      <= wdt_pkg::WDT_MODE_INTERVAL; // R4
        timer_enable_bit_reg <= CSR_INIT[`WDT_CSR_TME_BIT];
        clk_sel_reg          <= wdt_pkg::WDT_DIV2;
      end else if (wr_csr) begin
        mode_select_reg      <= wdt_pkg::wdt_mode_e'(wr_low[`WDT_CSR_MODE_BIT]); // R7
        timer_enable_bit_reg <= wr_low[`WDT_CSR_TME_BIT]; // R8
        clk_sel_reg          <= wdt_pkg::wdt_clksel_e'(wr_low[2:0]); // R10
      end
    end
  end

  // reset_control_status: only the pin resets it, not the internal reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      watchdog_overflow_flag_reg <= RST_INIT[`WDT_RST_WATCHDOG_OVERFLOW_FLAG_BIT]; // R11
      chip_reset_enable_reg      <= RST_INIT[`WDT_RST_CHIP_RESET_ENABLE_BIT];
      reset_type_select_reg      <= wdt_pkg::WDT_RST_POWER_ON;
    end else begin
      watchdog_overflow_flag_reg <= watchdog_overflow_flag_next;
      if (wr_rst_bits) begin
        chip_reset_enable_reg <= wr_low[`WDT_RST_CHIP_RESET_ENABLE_BIT]; // R15 R18
        reset_type_select_reg <=
            wdt_pkg::wdt_rst_type_e'(wr_low[`WDT_RST_RESET_TYPE_SELECT_BIT]); // R16 R18
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ovf_armed_reg  <= 1'b0;
      watchdog_overflow_flag_armed_reg <= 1'b0;
    end else begin
      ovf_armed_reg  <= ovf_armed_next;
      watchdog_overflow_flag_armed_reg <= watchdog_overflow_flag_armed_next;
    end
  end

  // pulse timers for the overflow pin and the chip reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_cnt_reg <= 10'd0;
      rst_cnt_reg <= 10'd0;
    end else begin
      out_cnt_reg <= out_cnt_next;
      rst_cnt_reg <= rst_cnt_next;
    end
  end

  // outputs follow the next-state counts so they change with the overflow edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_n_reg      <= 1'b1;
      rst_req_reg    <= 1'b0;
      rst_manual_reg <= 1'b0;
    end else begin
      out_n_reg   <= (out_cnt_next == 10'd0); // R19
      rst_req_reg <= (rst_cnt_next != 10'd0); // R20
      if (ovf_watchdog && chip_reset_enable_reg) begin
        rst_manual_reg <= (reset_type_select_reg == wdt_pkg::WDT_RST_MANUAL); // R16
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else if (bus_rd) begin
      rdata_reg <= rd_mux; // R9
    end
  end

  assign bus_rdata         = rdata_reg;
  assign overflow_out_n    = out_n_reg;
  assign interval_irq      = interval_overflow_flag_reg; // R22
  assign chip_reset_req    = rst_req_reg;
  assign chip_reset_manual = rst_manual_reg;

endmodule

// >>> verif/wdt_asserts.sv
`timescale 1ns/100ps
module wdt_chk (
  input wire logic        clk_sys,          // clock
  input wire logic        rstn,             // reset pin
  input wire logic        hw_standby,       // standby
  input wire logic        sw_standby,       // standby
  input wire logic [15:0] bus_addr,         // address
  input wire logic        bus_wr,           // write
  input wire logic        bus_word,         // word
  input wire logic [15:0] bus_wdata,        // data
  input wire logic        bus_rd,           // read
  input wire logic [7:0]  bus_rdata,        // read data
  input wire logic        overflow_out_n,   // pin
  input wire logic        interval_irq,     // irq
  input wire logic        chip_reset_req,   // reset out
  input wire logic        chip_reset_manual // reset kind
);
  logic [9:0] low_cnt;
  logic [9:0] req_cnt;
  // widths counted here, repetitions of 518 would crawl
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      low_cnt <= 10'h000;
      req_cnt <= 10'h000;
    end else begin
      low_cnt <= overflow_out_n ? 10'h000 : low_cnt + 10'h001;
      req_cnt <= chip_reset_req ? req_cnt + 10'h001 : 10'h000;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  quiet_reset_a: assert property ($rose(rstn) |-> overflow_out_n && !interval_irq
    && !chip_reset_req && bus_rdata == 8'h00) else $error("outputs busy after reset");
  pin_width_a: assert property ($rose(overflow_out_n) |->
    low_cnt == (chip_reset_req ? 10'h084 : 10'h082)) else $error("pin low width");
  pin_bound_a: assert property (!overflow_out_n |-> low_cnt <= 10'h083)
    else $error("pin low too long");
  reset_width_a: assert property ($fell(chip_reset_req) |-> req_cnt == 10'h206)
    else $error("chip reset width");
  reset_bound_a: assert property (chip_reset_req |-> req_cnt <= 10'h205)
    else $error("chip reset too long");
  reset_with_pin_a: assert property ($rose(chip_reset_req) |-> $fell(overflow_out_n))
    else $error("chip reset without pin");
  kind_steady_a: assert property (chip_reset_req && $past(chip_reset_req) |->
    $stable(chip_reset_manual)) else $error("reset kind moved");
  no_irq_wd_a: assert property ($fell(overflow_out_n) |-> !$rose(interval_irq))
    else $error("irq on watchdog overflow");
  flag_irq_a: assert property (bus_rd && bus_addr == 16'hFFBC |=>
    bus_rdata[7] == $past(interval_irq)) else $error("irq differs from flag");
  rsv_ones_a: assert property (bus_rd && bus_addr == 16'hFFBF |=>
    bus_rdata[4:0] == 5'h1F) else $error("reserved bits not one");
  cover property ($rose(interval_irq));
  cover property ($rose(chip_reset_req) && chip_reset_manual);
  cover property ($fell(overflow_out_n) && !chip_reset_req);
endmodule
bind wdt_top wdt_chk i_chk (
  .clk_sys(clk_sys), .rstn(rstn), .hw_standby(hw_standby), .sw_standby(sw_standby),
  .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_word(bus_word), .bus_wdata(bus_wdata),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .overflow_out_n(overflow_out_n),
  .interval_irq(interval_irq), .chip_reset_req(chip_reset_req),
  .chip_reset_manual(chip_reset_manual)
);

// >>> verif/wdt_top_bench.sv
`timescale 1ns/100ps
module wdt_top_bench;
  localparam logic [15:0] WA = 16'hFFBC;
  localparam logic [15:0] WB = 16'hFFBE;
  localparam logic [15:0] RN = 16'hFFBD;
  localparam logic [15:0] RB = 16'hFFBF;
  localparam logic [15:0] RC_ADDR = 16'hFFBC;
  logic        clk_sys;
  logic        rstn = 1'b0;
  logic        hw_standby = 1'b0;
  logic        sw_standby = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic        bus_wr = 1'b0;
  logic        bus_word = 1'b1;
  logic [15:0] bus_wdata = 16'h0000;
  logic        bus_rd = 1'b0;
  logic [7:0]  bus_rdata;
  logic        overflow_out_n;
  logic        interval_irq;
  logic        chip_reset_req;
  logic        chip_reset_manual;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          divs[8] = '{2, 64, 128, 512, 2048, 8192, 32768, 131072};
  wdt_top i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .hw_standby(hw_standby), .sw_standby(sw_standby),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_word(bus_word), .bus_wdata(bus_wdata),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .overflow_out_n(overflow_out_n),
    .interval_irq(interval_irq), .chip_reset_req(chip_reset_req),
    .chip_reset_manual(chip_reset_manual)
  );
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc >= 60000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic word = 1'b1);
    @(negedge clk_sys);
    bus_addr = a;
    bus_wdata = d;
    bus_word = word;
    bus_wr = 1'b1;
    @(negedge clk_sys);
    bus_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(negedge clk_sys);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk_sys);
    bus_rd = 1'b0;
    chk(what, {24'h000000, exp}, {24'h000000, bus_rdata});
  endtask
  function automatic logic pick(input int w);
    return w == 0 ? interval_irq : (w == 1 ? overflow_out_n : chip_reset_req);
  endfunction
  task automatic wait_for(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (pick(w) !== v && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    chk("wait", v, pick(w));
  endtask
  task automatic wd_run(input logic chip_reset_enable, input logic reset_type_select);
    int n;
    int m;
    wr(WB, {8'h5A, 1'b0, chip_reset_enable, reset_type_select, 5'h00});
    wr(WA, 16'hA560);
    wr(WA, 16'h5AFE);
    wait_for(1, 1'b0, 40, n);
    chk("chip reset", chip_reset_enable, chip_reset_req);
    if (chip_reset_enable) chk("reset kind", reset_type_select, chip_reset_manual);
    wr(WA, 16'hA527); // ignored while the pin is low
    wait_for(1, 1'b1, 200, n);
    chk("pin width", chip_reset_enable ? 132 : 130, n + 2);
    wait_for(2, 1'b0, 600, m);
    if (chip_reset_enable) chk("reset width", 518, n + m + 2);
    chk("irq", 1'b0, interval_irq);
    wr(WB, 16'hA500); // no read yet, so the flag must stay
    rd(RB, {1'b1, chip_reset_enable, reset_type_select, 5'h1F}, "reset status");
    rd(RC_ADDR, 8'h18, "csr reinit");
    wr(WB, 16'hA500);
    rd(RB, {1'b0, chip_reset_enable, reset_type_select, 5'h1F}, "flag cleared");
  endtask
  initial begin
    int n;
    int t0;
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    rd(WA, 8'h18, "csr reset");
    rd(RN, 8'h00, "count reset");
    rd(RB, 8'h1F, "reset status");
    rd(16'hFFB0, 8'h00, "unmapped");
    for (int k = 0; k < 8; k++) begin
      wr(WA, {8'hA5, 5'h00, k[2:0]});
      rd(WA, {5'h03, k[2:0]}, "clock select");
    end
    wr(WA, 16'hA500);
    wr(WA, 16'h5A77);
    rd(RN, 8'h00, "held count");
    wr(WA, 16'hA520);
    wr(WA, 16'h5AFE);
    wait_for(0, 1'b1, 40, n);
    wr(WA, 16'hA520);
    chk("irq unread", 1'b1, interval_irq);
    rd(WA, 8'hB8, "interval flag");
    wr(WA, 16'hA5A0);
    chk("irq one write", 1'b1, interval_irq);
    wr(WA, 16'hA520);
    chk("irq cleared", 1'b0, interval_irq);
    // slowest divider never ticks within this run, so counts stay exact
    wr(WA, 16'hA527);
    wr(WA, 16'h5A40);
    wr(WA, 16'h5A11, 1'b0);
    wr(WA, 16'h3311);
    rd(RN, 8'h40, "keyed count");
    sw_standby = 1'b1;
    wr(WA, 16'hA520); // fastest divider: any tick would show in the count
    rd(RN, 8'h40, "soft count");
    rd(WA, 8'h38, "soft csr");
    sw_standby = 1'b0;
    hw_standby = 1'b1;
    @(negedge clk_sys);
    hw_standby = 1'b0;
    rd(RN, 8'h00, "hard count");
    rd(WA, 8'h18, "hard csr");
    for (int k = 1; k < 6; k++) begin
      wr(WA, 16'hA500);
      wr(WA, {8'hA5, 5'h04, k[2:0]});
      wr(WA, 16'h5AFF);
      wait_for(0, 1'b1, divs[k] + 20, n);
      t0 = cyc;
      rd(WA, {5'h17, k[2:0]}, "tick flag");
      wr(WA, {8'hA5, 5'h04, k[2:0]});
      chk("irq", 1'b0, interval_irq);
      wr(WA, 16'h5AFF);
      wait_for(0, 1'b1, divs[k] + 20, n);
      chk("tick period", divs[k], cyc - t0);
      rd(WA, {5'h17, k[2:0]}, "tick flag");
    end
    wr(WA, 16'hA500);
    wd_run(1'b1, 1'b1);
    wd_run(1'b1, 1'b0);
    wd_run(1'b0, 1'b0);
    wr(WB, 16'h5A60);
    rstn = 1'b0;
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    rd(RB, 8'h1F, "pin reset");
    give_verdict();
  end
endmodule
